// [tb.sv]
// Self-checking bench of the zoom/decimate/window chain.
// Assumes the chain answers APB with pready and a 16-sample record.
`timescale 1ns/10ps
`default_nettype none
`include "zdw_cfg.svh"
module tb
  import zdw_pkg::*;
;
  typedef struct
  {
    logic        wr;
    logic [11:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
  } zdw_row_t;

  logic        core_clk_in;
  logic        resetn_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        adc_valid_in;
  logic [15:0] adc_data_in;
  logic        rec_valid_out;
  logic        rec_ready_in;
  zdw_cplx_t   rec_data_out;
  logic        rec_last_out;
  logic        rec_done_out;
  logic        stall_on;
  int          words;
  int          lasts;
  int          hold_err;
  int          error_cnt;
  int          checks_done;
  int          dones = 0;
  logic [31:0] r;
  logic        e;
  zdw_row_t    rows [9];

  zdw_chain #(.REC_LOG2(4), .MAX_STAGES(7)) u_zdw_chain (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in), .rec_valid_out(rec_valid_out),
    .rec_ready_in(rec_ready_in), .rec_data_out(rec_data_out), .rec_last_out(rec_last_out),
    .rec_done_out(rec_done_out));

  zdw_rec_sink_model u_zdw_rec_sink_model (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .stall_in(stall_on), .valid_in(rec_valid_out), .data_in(rec_data_out), .last_in(rec_last_out),
    .ready_out(rec_ready_in), .words_out(words), .lasts_out(lasts), .hold_err_out(hold_err));

  // Done pulses are counted on the falling edge, where the registered pulse has settled.
  always @(negedge core_clk_in)
    if (rec_done_out === 1'b1)
      dones <= dones + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The master never assumes a wait count; it holds the request until pready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
    end while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Sends 64 DC samples back to back under a new span, then drains the pipeline.
  // Without arm the equalizer is left in its bypass state for the whole run.
  task automatic run(input logic [31:0] ctrl, input logic [31:0] ratio, input int lo, input int hi,
                     input logic stall, input logic arm = 1'b1);
    int w0;
    apb(1'b1, `ZDW_OFF_CTRL, ctrl);
    apb(1'b1, `ZDW_OFF_RATIO, ratio);
    apb(1'b0, `ZDW_OFF_STAT, 32'h0);
    chk(r[16] === 1'b0, "equalizer still armed after span change");
    if (arm)
    begin
      apb(1'b1, `ZDW_OFF_EQ3, 32'h0);
      apb(1'b0, `ZDW_OFF_STAT, 32'h0);
      chk(r[16] === 1'b1, "equalizer not armed");
    end
    stall_on <= stall;
    w0 = words;
    repeat (64)
    begin
      @(posedge core_clk_in);
      adc_valid_in <= 1'b1;
      adc_data_in <= 16'h1000;
    end
    @(posedge core_clk_in);
    adc_valid_in <= 1'b0;
    repeat (80) @(posedge core_clk_in);
    stall_on <= 1'b0;
    chk(words - w0 >= lo && words - w0 <= hi, "output word count");
  endtask

  // Checks the last full record: imaginary zero, then flat or tapered real part.
  task automatic win_chk(input logic flat);
    int   diff;
    logic izero;
    diff = 0;
    izero = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      if (u_zdw_rec_sink_model.rec[i].re !== u_zdw_rec_sink_model.rec[0].re)
        diff++;
      if (u_zdw_rec_sink_model.rec[i].im !== 16'h0)
        izero = 1'b0;
    end
    chk(izero, "imaginary part not zero");
    if (flat)
      chk(diff == 0, "uniform record not flat");
    else
      chk(u_zdw_rec_sink_model.rec[0].re < u_zdw_rec_sink_model.rec[8].re, "record end not tapered");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    rows = '{'{1'b0, `ZDW_OFF_CTRL, 32'h0, 32'h0}, '{1'b0, `ZDW_OFF_RATIO, 32'h0, 32'h0001_0000},
             '{1'b0, `ZDW_OFF_EQ0, 32'h0, 32'h0000_4000}, '{1'b0, `ZDW_OFF_STAT, 32'h0, 32'h0},
             '{1'b0, `ZDW_OFF_RECS, 32'h0, 32'h0}, '{1'b1, `ZDW_OFF_ZFREQ, 32'h1234_5678, 32'h1234_5678},
             '{1'b1, `ZDW_OFF_RATIO, 32'hfff8_8000, 32'h0000_8000},
             '{1'b1, 12'h014, 32'h1234_ffff, 32'h0000_ffff}, '{1'b1, `ZDW_OFF_CTRL, 32'hffff_ffff, 32'hffff_ffff}};
    error_cnt = 0;
    checks_done = 0;
    resetn_in = 1'b0;
    {psel_in, penable_in, pwrite_in, adc_valid_in, stall_on} = 5'h0;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    adc_data_in = 16'h0;
    repeat (8) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    chk(rec_valid_out === 1'b0 && rec_done_out === 1'b0, "stream active after reset");
    foreach (rows[i])
    begin
      if (rows[i].wr)
        apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      chk(r === rows[i].exp && e === 1'b0, "register readback");
    end
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    chk(e === 1'b1, "unmapped write accepted");
    apb(1'b0, 12'h00c, 32'h0);
    chk(e === 1'b1 && r === 32'h0, "unmapped read");
    apb(1'b1, `ZDW_OFF_ZFREQ, 32'h0);
    apb(1'b1, 12'h014, 32'h0);
    run(32'h10, 32'h1_0000, 64, 64, 1'b0);
    win_chk(1'b1);
    run(32'h110, 32'h1_0000, 32, 32, 1'b0);
    run(32'h210, 32'h1_0000, 16, 16, 1'b1);
    chk(hold_err == 0, "stalled word changed or lost");
    run(32'h00, 32'h1_0000, 64, 64, 1'b0);
    win_chk(1'b0);
    run(32'h02, 32'h1_0000, 64, 64, 1'b0);
    win_chk(1'b1);
    run(32'h11, 32'h1_0000, 64, 64, 1'b0);
    win_chk(1'b1);
    apb(1'b0, `ZDW_OFF_RECS, 32'h0);
    chk(lasts == 19 && r === 32'd19, "record count");
    run(32'h10, 32'h0_8000, 31, 33, 1'b0);
    apb(1'b0, `ZDW_OFF_RECS, 32'h0);
    chk(r === lasts && dones == lasts, "records done against records marked");
    // A stalled sink at full input rate overfills the memory, so fewer than 64 words come out.
    run(32'h10, 32'h1_0000, 40, 56, 1'b1, 1'b0);
    chk(hold_err == 0, "stalled word changed under overflow");
    resetn_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    chk(rec_valid_out === 1'b0 && rec_done_out === 1'b0, "stream active in reset");
    resetn_in <= 1'b1;
    apb(1'b0, `ZDW_OFF_RECS, 32'h0);
    chk(r === 32'h0, "record count kept over reset");
    report_and_stop();
  end
endmodule
`default_nettype wire

// [zdw_cfg.svh]
// Register offsets, field positions and reset values of the zoom/decimate/window chain.
// Assumes a 32-bit APB slave with word-aligned byte addresses.
`ifndef ZDW_CFG_SVH
`define ZDW_CFG_SVH
`define ZDW_OFF_CTRL   12'h000
`define ZDW_OFF_ZFREQ  12'h004
`define ZDW_OFF_RATIO  12'h008
`define ZDW_OFF_EQ0    12'h010
`define ZDW_OFF_EQ3    12'h01c
`define ZDW_OFF_STAT   12'h020
`define ZDW_OFF_RECS   12'h024
`define ZDW_CTRL_ZOOM  0
`define ZDW_CTRL_OVR   1
`define ZDW_CTRL_WSEL  2
`define ZDW_CTRL_MEAS  4
`define ZDW_CTRL_DEC   8
`define ZDW_RST_RATIO  17'h10000
`define ZDW_RST_EQ     64'h0000_0000_0000_4000
`define ZDW_EQ_SHIFT   14
`define ZDW_WIN_SHIFT  15
`endif

// [zdw_chain.sv]
// Digital IF chain: zoom mixer, binary decimators, resampler, equalizer,
// circular record memory and windowing, with an APB register port.
// Assumes ADC samples arrive on core_clk_in from logic on the same clock.
//
// Functional notes
// - Each stage outputs at input rate over n.
// - Each stage low-passes by its rate factor.
// - Enabled stage count sets power-of-two rate.
// - Resampler after decimators gives arbitrary ratio.
// - Zoom multiplies input by complex sinusoid.
// - Zoomed complex signal is filtered and decimated.
// - Span changes keep zoom center frequency.
// - Output fills circular memory in fixed records.
// - Equalizer filter corrects the time data.
// - Span sets stages, ratio; coefficients follow.
// - Each record sample weighted by window.
// - Window follows measurement type unless overridden.
// - Uniform window has all weights equal.
`timescale 1ns/10ps
`default_nettype none
`include "zdw_cfg.svh"
module zdw_chain
  import zdw_pkg::*;
#(
  parameter int REC_LOG2   = 6,
  parameter int MAX_STAGES = 7
)
(
  input  wire logic               core_clk_in,
  input  wire logic               resetn_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire logic [11:0]        paddr_in,
  input  wire logic [31:0]        pwdata_in,
  output logic [31:0]             prdata_out,
  output logic                    pready_out,
  output logic                    pslverr_out,
  input  wire logic               adc_valid_in,
  input  wire logic signed [15:0] adc_data_in,
  output logic                    rec_valid_out,
  input  wire logic               rec_ready_in,
  output zdw_cplx_t               rec_data_out,
  output logic                    rec_last_out,
  output logic                    rec_done_out
);
  localparam int REC = 2 ** REC_LOG2;
  localparam int RW = REC_LOG2;
  localparam logic [15:0] QTAB [17] = '{16'h7fff, 16'h7f62, 16'h7d8a, 16'h7a7d, 16'h7642, 16'h70e3,
    16'h6a6e, 16'h62f2, 16'h5a82, 16'h5134, 16'h471d, 16'h3c57, 16'h30fc, 16'h2528, 16'h18f9,
    16'h0c8c, 16'h0000};
  // Half of each symmetric window, from the record edge to its centre.
  localparam logic [15:0] WTAB [4][8] = '{
    '{16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff},
    '{16'h013b, 16'h0aca, 16'h1c71, 16'h3385, 16'h4c7a, 16'h638e, 16'h7535, 16'h7ec4},
    '{16'h0400, 16'h0c00, 16'h1e00, 16'h3800, 16'h5400, 16'h6c00, 16'h7a00, 16'h7fff},
    '{16'h0000, 16'h0200, 16'h0a00, 16'h2000, 16'h4000, 16'h6000, 16'h7800, 16'h7fff}};

  typedef struct packed
  {
    logic [31:0]                ctrl;
    logic [31:0]                zfreq;
    logic [16:0]                ratio;
    logic [3:0][15:0]           eq;
    logic                       armed;
    logic [31:0]                prdata;
    logic [31:0]                phase;
    zdw_cplx_t                  mix;
    logic                       mix_v;
    zdw_cplx_t                  rs_prev;
    logic [15:0]                rs_acc;
    zdw_cplx_t                  rs_o;
    logic                       rs_v;
    zdw_cplx_t [2:0]            tap;
    zdw_cplx_t                  eq_o;
    logic                       eq_v;
    zdw_cplx_t [REC-1:0]        mem;
    logic [REC-1:0][RW-1:0]     pos;
    logic [RW-1:0]              wp;
    logic [RW-1:0]              rp;
    logic [RW-1:0]              wpos;
    logic [RW:0]                cnt;
    logic                       done;
    logic [15:0]                nrec;
  } zdw_st_t;

  localparam zdw_st_t ST_RST = '{ratio: `ZDW_RST_RATIO, eq: `ZDW_RST_EQ, default: '0};

  zdw_st_t            s;
  zdw_st_t            n;
  logic               dv [MAX_STAGES+1];
  zdw_cplx_t          dd [MAX_STAGES+1];
  logic               acc;
  logic               wr;
  logic               push;
  logic               pop;
  logic               full;
  logic               sk_ready;
  logic signed [15:0] cos_w;
  logic signed [15:0] sin_w;
  logic signed [31:0] m_re;
  logic signed [31:0] m_im;
  logic [16:0]        acc_sum;
  logic [RW-1:0]      rpos;
  logic [2:0]         wh;
  logic [15:0]        wgt;
  zdw_win_t           win;
  zdw_cplx_t          raw;
  zdw_out_t           wout;
  zdw_out_t           sk_out;

  function automatic logic mapped(input logic [11:0] a);
    return a == `ZDW_OFF_CTRL || a == `ZDW_OFF_ZFREQ || a == `ZDW_OFF_RATIO || a == `ZDW_OFF_STAT ||
           a == `ZDW_OFF_RECS || (a >= `ZDW_OFF_EQ0 && a <= `ZDW_OFF_EQ3 && a[1:0] == 2'h0);
  endfunction

  function automatic logic signed [15:0] cosq(input logic [5:0] p);
    logic [4:0] k;
    k = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
    return (p[5] ^ p[4]) ? -$signed(QTAB[k]) : $signed(QTAB[k]);
  endfunction

  function automatic logic signed [15:0] lerp(input logic signed [15:0] a, b, input logic [15:0] f);
    logic signed [16:0] d;
    logic signed [33:0] p;
    d = 17'(b) - 17'(a);
    p = d * $signed({1'b0, f});
    return b - 16'(p >>> 16);
  endfunction

  function automatic zdw_cplx_t fir(input zdw_cplx_t [3:0] x, input logic [3:0][15:0] c);
    logic signed [35:0] ar;
    logic signed [35:0] ai;
    ar = '0;
    ai = '0;
    for (int k = 0; k < 4; k++)
    begin
      ar = ar + 36'(x[k].re * $signed(c[k]));
      ai = ai + 36'(x[k].im * $signed(c[k]));
    end
    return '{re: 16'(ar >>> `ZDW_EQ_SHIFT), im: 16'(ai >>> `ZDW_EQ_SHIFT)};
  endfunction

  function automatic logic signed [15:0] wmul(input logic signed [15:0] x, input logic [15:0] w);
    logic signed [32:0] p;
    p = x * $signed({1'b0, w});
    return 16'(p >>> `ZDW_WIN_SHIFT);
  endfunction

  function automatic zdw_win_t auto_win(input zdw_meas_t m);
    case (m)
      ZDW_MEAS_TRANSIENT: return ZDW_WIN_UNIFORM;
      ZDW_MEAS_DYNAMIC:   return ZDW_WIN_GAUSS;
      ZDW_MEAS_ACCURACY:  return ZDW_WIN_FLAT;
      default:            return ZDW_WIN_HANN;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register port. Zero wait states; read data is caught in the setup cycle.
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in && mapped(paddr_in);
  assign pready_out = 1'b1;
  assign pslverr_out = acc && !mapped(paddr_in);
  assign prdata_out = s.prdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Mixer products and the decimator chain.
  assign cos_w = cosq(s.phase[31:26]);
  assign sin_w = cosq(s.phase[31:26] - 6'h10);
  assign m_re = adc_data_in * cos_w;
  assign m_im = adc_data_in * sin_w;
  assign dv[0] = s.mix_v;
  assign dd[0] = s.mix;

  for (genvar i = 0; i < MAX_STAGES; i++)
  begin : g_dec
    zdw_halfband u_hb (
      .core_clk_in   (core_clk_in),
      .resetn_in     (resetn_in),
      .en_in         (s.ctrl[`ZDW_CTRL_DEC +: 3] > 3'(i)),
      .in_valid_in   (dv[i]),
      .in_in         (dd[i]),
      .out_valid_out (dv[i+1]),
      .out_out       (dd[i+1])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Record memory read side, window and output buffer.
  assign acc_sum = {1'b0, s.rs_acc} + s.ratio;
  assign full = s.cnt == (RW+1)'(REC);
  assign push = s.eq_v;
  assign pop = s.cnt != '0 && sk_ready;
  assign rpos = s.pos[s.rp];
  assign wh = rpos[RW-1] ? ~rpos[RW-2 -: 3] : rpos[RW-2 -: 3];
  assign win = s.ctrl[`ZDW_CTRL_OVR] ? zdw_win_t'(s.ctrl[`ZDW_CTRL_WSEL +: 2])
             : auto_win(zdw_meas_t'(s.ctrl[`ZDW_CTRL_MEAS +: 2]));
  assign wgt = WTAB[win][wh];
  assign raw = s.mem[s.rp];
  assign wout.last = rpos == RW'(REC - 1);
  assign wout.d.re = wmul(raw.re, wgt);
  assign wout.d.im = wmul(raw.im, wgt);

  zdw_skid #(.W($bits(zdw_out_t))) u_skid (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (pop),
    .in_ready_out  (sk_ready),
    .in_data_in    (wout),
    .out_valid_out (rec_valid_out),
    .out_ready_in  (rec_ready_in),
    .out_data_out  (sk_out)
  );

  assign rec_data_out = sk_out.d;
  assign rec_last_out = sk_out.last;
  assign rec_done_out = s.done;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = s;
    if (psel_in && !penable_in)
    begin
      if (paddr_in == `ZDW_OFF_CTRL)
        n.prdata = s.ctrl;
      else if (paddr_in == `ZDW_OFF_ZFREQ)
        n.prdata = s.zfreq;
      else if (paddr_in == `ZDW_OFF_RATIO)
        n.prdata = 32'(s.ratio);
      else if (mapped(paddr_in) && paddr_in[11:4] == 8'h01)
        n.prdata = 32'(s.eq[paddr_in[3:2]]);
      else if (paddr_in == `ZDW_OFF_STAT)
        n.prdata = {15'h0000, s.armed, 16'(s.cnt)};
      else if (paddr_in == `ZDW_OFF_RECS)
        n.prdata = 32'(s.nrec);
      else
        n.prdata = 32'h0000_0000;
    end
    if (wr)
    begin
      if (paddr_in == `ZDW_OFF_CTRL)
      begin
        n.ctrl = pwdata_in;
        n.armed = 1'b0;
      end
      else if (paddr_in == `ZDW_OFF_ZFREQ)
        n.zfreq = pwdata_in;
      else if (paddr_in == `ZDW_OFF_RATIO)
      begin
        n.ratio = pwdata_in[16:0];
        n.armed = 1'b0;
      end
      else if (paddr_in[11:4] == 8'h01)
      begin
        n.eq[paddr_in[3:2]] = pwdata_in[15:0];
        if (paddr_in[3:2] == 2'h3)
          n.armed = 1'b1;
      end
    end
    // Zoom phase runs on its own; span writes never touch it, so the centre stays put.
    n.mix_v = adc_valid_in;
    if (adc_valid_in)
    begin
      if (s.ctrl[`ZDW_CTRL_ZOOM])
      begin
        n.phase = s.phase + s.zfreq;
        n.mix.re = m_re[30:15];
        n.mix.im = -m_im[30:15];
      end
      else
      begin
        n.mix.re = adc_data_in;
        n.mix.im = '0;
      end
    end
    // Ratio is output samples per input, unity at the reset value; one output per input at most.
    n.rs_v = 1'b0;
    if (dv[MAX_STAGES])
    begin
      n.rs_prev = dd[MAX_STAGES];
      n.rs_acc = acc_sum[15:0];
      n.rs_v = acc_sum[16];
      n.rs_o.re = lerp(s.rs_prev.re, dd[MAX_STAGES].re, acc_sum[15:0]);
      n.rs_o.im = lerp(s.rs_prev.im, dd[MAX_STAGES].im, acc_sum[15:0]);
    end
    // Until EQ3 is written after the span, the equalizer passes data unchanged.
    n.eq_v = s.rs_v;
    if (s.rs_v)
    begin
      n.tap = {s.tap[1:0], s.rs_o};
      n.eq_o = s.armed ? fir({s.tap, s.rs_o}, s.eq) : s.rs_o;
    end
    n.done = 1'b0;
    if (push)
    begin
      n.mem[s.wp] = s.eq_o;
      n.pos[s.wp] = s.wpos;
      n.wp = s.wp + 1'b1;
      n.wpos = s.wpos + 1'b1;
      if (s.wpos == RW'(REC - 1))
      begin
        n.done = 1'b1;
        n.nrec = s.nrec + 16'h0001;
      end
    end
    if (pop || (push && full))
      n.rp = s.rp + 1'b1;
    if (push && !pop && !full)
      n.cnt = s.cnt + 1'b1;
    else if (pop && !push)
      n.cnt = s.cnt - 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= ST_RST;
    else
      s <= n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_done;
    push && s.wpos == RW'(REC - 1) |=> rec_done_out ##1 !rec_done_out;
  endproperty
  a_done: assert property (p_done) else $error("record done pulse wrong");
  property p_over;
    push && full && !pop |=> full && s.rp == $past(s.rp) + 1'b1;
  endproperty
  a_over: assert property (p_over) else $error("oldest sample not dropped");
  property p_base;
    adc_valid_in && !s.ctrl[`ZDW_CTRL_ZOOM] |=> s.mix_v && s.mix.im == 0 && s.mix.re == $past(adc_data_in);
  endproperty
  a_base: assert property (p_base) else $error("baseband bypass wrong");
  property p_zoom;
    adc_valid_in && s.ctrl[`ZDW_CTRL_ZOOM] |=> s.phase == $past(s.phase) + $past(s.zfreq);
  endproperty
  a_zoom: assert property (p_zoom) else $error("zoom phase step wrong");
  property p_disarm;
    wr && paddr_in == `ZDW_OFF_CTRL |=> !s.armed;
  endproperty
  a_disarm: assert property (p_disarm) else $error("equalizer not disarmed");
  property p_auto;
    wr && paddr_in == `ZDW_OFF_CTRL && !pwdata_in[`ZDW_CTRL_OVR]
    && pwdata_in[`ZDW_CTRL_MEAS +: 2] == 2'(ZDW_MEAS_TRANSIENT) |=> win == ZDW_WIN_UNIFORM;
  endproperty
  a_auto: assert property (p_auto) else $error("auto window wrong");
  property p_hold;
    rec_valid_out && !rec_ready_in |=> rec_valid_out && $stable(rec_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output dropped under stall");
  property p_eq;
    s.rs_v && !s.armed |=> s.eq_v && s.eq_o == $past(s.rs_o);
  endproperty
  a_eq: assert property (p_eq) else $error("equalizer bypass wrong");
  property p_taper;
    pop && win == ZDW_WIN_HANN && rpos == '0 |-> wout.d.re <= 16'sd316 && wout.d.re >= -16'sd316;
  endproperty
  a_taper: assert property (p_taper) else $error("window edge not tapered");

  c_done: cover property (rec_done_out && s.ctrl[`ZDW_CTRL_ZOOM]);
  c_over: cover property (push && full && !pop);
  c_ovr: cover property (pop && s.ctrl[`ZDW_CTRL_OVR] && win == ZDW_WIN_FLAT);
  c_armed: cover property (s.eq_v && s.armed);
endmodule
`default_nettype wire

// [zdw_halfband.sv]
// One binary decimating stage: [1 2 1]/4 low-pass, keeps every second sample.
// Assumes the same clock as its neighbours; a disabled stage forwards each sample.
`timescale 1ns/10ps
`default_nettype none
module zdw_halfband
  import zdw_pkg::*;
(
  input  wire logic      core_clk_in,
  input  wire logic      resetn_in,
  input  wire logic      en_in,
  input  wire logic      in_valid_in,
  input  wire zdw_cplx_t in_in,
  output logic           out_valid_out,
  output zdw_cplx_t      out_out
);
  typedef struct packed
  {
    zdw_cplx_t d1;
    zdw_cplx_t d2;
    zdw_cplx_t o;
    logic      ph;
    logic      v;
  } zdw_hb_t;

  zdw_hb_t s;
  zdw_hb_t nx;

  function automatic logic signed [15:0] lp(input logic signed [15:0] a, b, c);
    logic signed [17:0] t;
    t = {{2{a[15]}}, a} + {b[15], b, 1'b0} + {{2{c[15]}}, c};
    return t[17:2];
  endfunction

  always_comb
  begin
    nx = s;
    nx.v = 1'b0;
    if (in_valid_in)
    begin
      nx.d1 = in_in;
      nx.d2 = s.d1;
      if (!en_in)
      begin
        nx.o = in_in;
        nx.v = 1'b1;
        nx.ph = 1'b0;
      end
      else
      begin
        // The [1 2 1] kernel halves the band before every second sample is dropped.
        nx.o.re = lp(in_in.re, s.d1.re, s.d2.re);
        nx.o.im = lp(in_in.im, s.d1.im, s.d2.im);
        nx.v = s.ph;
        nx.ph = ~s.ph;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= '0;
    else
      s <= nx;
  end

  assign out_valid_out = s.v;
  assign out_out = s.o;

  property p_half_rate;
    @(posedge core_clk_in) disable iff (!resetn_in)
    en_in && in_valid_in |=> out_valid_out == $past(s.ph);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("decimator rate wrong");
endmodule
`default_nettype wire

// [zdw_pkg.sv]
// Types shared by the zoom/decimate/window chain.
// Assumes 16-bit signed two's complement samples.
package zdw_pkg;
  typedef struct packed
  {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } zdw_cplx_t;

  typedef struct packed
  {
    logic      last;
    zdw_cplx_t d;
  } zdw_out_t;

  typedef enum logic [1:0] {ZDW_WIN_UNIFORM, ZDW_WIN_HANN, ZDW_WIN_GAUSS, ZDW_WIN_FLAT} zdw_win_t;
  typedef enum logic [1:0] {ZDW_MEAS_SPECTRUM, ZDW_MEAS_TRANSIENT, ZDW_MEAS_DYNAMIC,
                            ZDW_MEAS_ACCURACY} zdw_meas_t;
endpackage

// [zdw_rec_sink_model.sv]
// Consumer model for the finished record stream, standing in for the FFT stage.
// Assumes the chain's clock; stall_in drops ready on alternate cycles.
`timescale 1ns/10ps
`default_nettype none
module zdw_rec_sink_model
  import zdw_pkg::*;
(
  input  wire logic      core_clk_in,
  input  wire logic      resetn_in,
  input  wire logic      stall_in,
  input  wire logic      valid_in,
  input  wire zdw_cplx_t data_in,
  input  wire logic      last_in,
  output logic           ready_out,
  output int             words_out,
  output int             lasts_out,
  output int             hold_err_out
);
  zdw_cplx_t rec [16];
  int        pos;
  logic      held;
  zdw_out_t  prev;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ready_out <= 1'b0;
      words_out <= 0;
      lasts_out <= 0;
      hold_err_out <= 0;
      pos <= 0;
      held <= 1'b0;
    end
    else
    begin
      // A stalled word must come back unchanged on the next cycle.
      if (held && (valid_in !== 1'b1 || {last_in, data_in} !== prev))
        hold_err_out <= hold_err_out + 1;
      held <= valid_in && !ready_out;
      prev <= {last_in, data_in};
      ready_out <= stall_in ? !ready_out : 1'b1;
      if (valid_in && ready_out)
      begin
        words_out <= words_out + 1;
        rec[pos[3:0]] <= data_in;
        pos <= last_in ? 0 : pos + 1;
        if (last_in)
          lasts_out <= lasts_out + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [zdw_skid.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes the sink may hold ready low for any time; the source then sees ready low.
`timescale 1ns/10ps
`default_nettype none
module zdw_skid
#(
  parameter int W = 33
)
(
  input  wire logic         core_clk_in,
  input  wire logic         resetn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  typedef struct packed
  {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0]   n;
  } zdw_sk_t;

  zdw_sk_t s;
  zdw_sk_t nx;
  logic    push;
  logic    pop;

  assign in_ready_out = s.n != 2'd2;
  assign out_valid_out = s.n != 2'd0;
  assign out_data_out = s.e0;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;

  always_comb
  begin
    nx = s;
    if (pop && s.n == 2'd2)
      nx.e0 = s.e1;
    if (push)
    begin
      if (s.n == 2'd0 || pop)
        nx.e0 = in_data_in;
      else
        nx.e1 = in_data_in;
    end
    nx.n = s.n + 2'(push) - 2'(pop);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      s <= '0;
    else
      s <= nx;
  end
endmodule
`default_nettype wire
